// ==== hdl/blf_params.svh ====
// constants for the backlight level and fade sequencer
// Operation
// - codes are seven bits, 128 levels
// - law 00 gives linear current
// - law 01 gives square current
// - light on request turns backlight on/off
// - dim request selects dim code
// - enabled key press sets light on
// - dim timer expiry sets dim request
// - dim clear or reassert restarts dim
// - off timer expiry clears light on
// - reassert restarts off countdown
// - clearing light on turns off or fades
// - sequence max, dim, then off
// - ramp up full scale 0.3-5.5 s
// - ramp down full scale 0.3-5.5 s
// - reassert during fade-out ramps up from present
// - ramp up and down enabled separately
// - ramp skip jumps to maximum code
// - square law fades step square codes
// - level field picks daylight/office/dark pair
// - steps spread evenly over fade time
`ifndef BLF_PARAMS_SVH
`define BLF_PARAMS_SVH

// ==========================================
// widths and encodings
`define BLF_CODE_W 7
`define BLF_CUR_W 14
`define BLF_SEL_W 4
`define BLF_CNT_W 32
`define BLF_SEC_W 8
`define BLF_FULL_CODE 7'h7f
`define BLF_LAW_LINEAR 2'h0
`define BLF_LAW_SQUARE 2'h1
`define BLF_LVL_DAY 2'h0
`define BLF_LVL_OFFICE 2'h1
`define BLF_LVL_DARK 2'h2

// ==========================================
// timing
`define BLF_CLK_HZ 20000000
`define BLF_SEC_TIME_MS 1000
`define BLF_TENTH_TIME_MS 100
// dim/off delays in seconds, setting 1 in the low byte
`define BLF_DELAY_SEC_TABLE 120'h78_64_50_46_3c_37_32_2d_28_23_1e_19_14_0f_0a
// full-scale ramp times in tenths of a second, setting 1 in the low byte
`define BLF_RAMP_TENTHS_TABLE 120'h37_32_2d_28_23_1e_1b_18_15_12_0f_0c_09_06_03
`define BLF_TABLE_ENTRY_W 8

`endif

// ==== hdl/blf_pkg.sv ====
// types shared by the backlight fade sequencer
`include "blf_params.svh"
package blf_pkg;

	typedef logic [`BLF_CODE_W-1:0] blf_code_type;
	typedef logic [`BLF_CUR_W-1:0] blf_current_type;
	typedef logic [`BLF_SEL_W-1:0] blf_sel_type;
	typedef logic [1:0] blf_mode_type;

	typedef enum logic [1:0] {
		BLF_OFF,
		BLF_MAX,
		BLF_DIM
	} blf_light_type;

	typedef struct packed {
		blf_light_type light;
		blf_code_type code;
		blf_code_type code_dly;
		logic [`BLF_CNT_W-1:0] step_cnt;
		logic [`BLF_CNT_W-1:0] sec_cnt;
		logic [`BLF_SEC_W-1:0] dim_cnt;
		logic [`BLF_SEC_W-1:0] off_cnt;
		blf_current_type current;
	} blf_state_type;

endpackage

// ==== hdl/blf_sequencer.sv ====
// backlight on/dim/off sequencer with dim and off timers and fade ramps
`timescale 1ns/1ns
`include "blf_params.svh"
module blf_sequencer
	import blf_pkg::*;
#(
	parameter int SEC_CYCLES = `BLF_CLK_HZ / 1000 * `BLF_SEC_TIME_MS,
	parameter int TENTH_CYCLES = `BLF_CLK_HZ / 1000 * `BLF_TENTH_TIME_MS
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic operating_not_standby,
	input wire logic light_on_request_wr,
	input wire logic light_on_request_wdata,
	input wire logic dim_request_wr,
	input wire logic dim_request_wdata,
	input wire logic keypad_matrix_mode,
	input wire logic keypress_wake_light,
	input wire logic key_press,
	input wire blf_pkg::blf_mode_type current_law_select,
	input wire blf_pkg::blf_mode_type ambient_level_select,
	input wire blf_pkg::blf_code_type daylight_max_code,
	input wire blf_pkg::blf_code_type daylight_dim_code,
	input wire blf_pkg::blf_code_type office_max_code,
	input wire blf_pkg::blf_code_type office_dim_code,
	input wire blf_pkg::blf_code_type dark_max_code,
	input wire blf_pkg::blf_code_type dark_dim_code,
	input wire blf_pkg::blf_sel_type dim_delay_setting,
	input wire blf_pkg::blf_sel_type off_delay_setting,
	input wire blf_pkg::blf_sel_type ramp_up_time,
	input wire blf_pkg::blf_sel_type ramp_down_time,
	input wire logic ramp_skip_on_reassert,
	output logic light_on_request,
	output logic dim_request,
	output blf_pkg::blf_code_type sink_code,
	output blf_pkg::blf_current_type sink_current,
	output logic ramp_active
);
	import blf_pkg::*;

	// ==========================================
	// elaboration checks
	if (SEC_CYCLES < 1) begin : g_bad_sec
		$error("SEC_CYCLES must be at least one");
	end
	if (TENTH_CYCLES < `BLF_FULL_CODE) begin : g_bad_tenth
		$error("TENTH_CYCLES must be at least the full-scale code");
	end

	localparam logic [`BLF_CNT_W-1:0] SEC_LAST = `BLF_CNT_W'(SEC_CYCLES - 1);

	// ==========================================
	// table lookups
	function automatic logic [`BLF_TABLE_ENTRY_W-1:0] delay_seconds(input blf_sel_type sel);
		logic [119:0] tab;
		tab = `BLF_DELAY_SEC_TABLE;
		delay_seconds = tab[(int'(sel) - 1) * `BLF_TABLE_ENTRY_W +: `BLF_TABLE_ENTRY_W];
	endfunction

	// cycles per code step: the full-scale time spread over 127 steps
	function automatic logic [`BLF_CNT_W-1:0] step_length(input blf_sel_type sel);
		logic [119:0] tab;
		logic [`BLF_CNT_W-1:0] tenths;
		logic [`BLF_CNT_W-1:0] len;
		tab = `BLF_RAMP_TENTHS_TABLE;
		tenths = `BLF_CNT_W'(tab[(int'(sel) - 1) * `BLF_TABLE_ENTRY_W +: `BLF_TABLE_ENTRY_W]);
		len = tenths * `BLF_CNT_W'(TENTH_CYCLES) / `BLF_CNT_W'(`BLF_FULL_CODE);
		step_length = (len == '0) ? `BLF_CNT_W'(1) : len;
	endfunction

	blf_state_type q;
	blf_state_type d;
	blf_current_type square_current;

	// ==========================================
	// level pair selection
	blf_code_type max_code;
	blf_code_type dim_code;

	always_comb begin
		if (ambient_level_select == `BLF_LVL_DAY) begin
			max_code = daylight_max_code;
			dim_code = daylight_dim_code;
		end else if (ambient_level_select == `BLF_LVL_OFFICE) begin
			max_code = office_max_code;
			dim_code = office_dim_code;
		end else begin
			// the unused encoding falls to the dark pair
			max_code = dark_max_code;
			dim_code = dark_dim_code;
		end
	end

	// ==========================================
	// request events
	logic wake;
	logic reassert;
	logic sw_off;
	logic sw_dim_set;
	logic sw_dim_clr;
	logic sec_tick;
	logic dim_expired;
	logic off_expired;
	logic dim_timed;
	logic off_timed;

	always_comb begin
		wake = keypad_matrix_mode && keypress_wake_light && key_press;
		reassert = (light_on_request_wr && light_on_request_wdata) || wake;
		sw_off = light_on_request_wr && !light_on_request_wdata;
		sw_dim_set = dim_request_wr && dim_request_wdata;
		sw_dim_clr = dim_request_wr && !dim_request_wdata;
		sec_tick = (q.sec_cnt == SEC_LAST);
		dim_timed = (dim_delay_setting != '0);
		off_timed = (off_delay_setting != '0);
		dim_expired = operating_not_standby && dim_timed && (q.light == BLF_MAX)
			&& (q.dim_cnt >= delay_seconds(dim_delay_setting));
		off_expired = operating_not_standby && off_timed && (q.light != BLF_OFF)
			&& (q.off_cnt >= delay_seconds(off_delay_setting));
	end

	// ==========================================
	// target code of the present state
	blf_code_type target;
	logic ramping;
	logic step_due_up;
	logic step_due_down;

	always_comb begin
		// standby forces the sink dark without touching the request bits
		if (!operating_not_standby || q.light == BLF_OFF) begin
			target = '0;
		end else if (q.light == BLF_DIM) begin
			target = dim_code;
		end else begin
			target = max_code;
		end
		ramping = (q.code != target);
		step_due_up = (q.step_cnt >= step_length(ramp_up_time) - `BLF_CNT_W'(1));
		step_due_down = (q.step_cnt >= step_length(ramp_down_time) - `BLF_CNT_W'(1));
	end

	// ==========================================
	// next state
	always_comb begin
		d = q;

		// seconds timebase, realigned on each turn-on so delays start whole
		if (sec_tick || reassert) begin
			d.sec_cnt = '0;
		end else begin
			d.sec_cnt = q.sec_cnt + `BLF_CNT_W'(1);
		end

		// timers count whole seconds while operating, the dim timer at max only, the off timer while lit
		if (sec_tick && operating_not_standby) begin
			if (q.light == BLF_MAX && dim_timed && !dim_expired) begin
				d.dim_cnt = q.dim_cnt + `BLF_SEC_W'(1);
			end
			if (q.light != BLF_OFF && off_timed && !off_expired) begin
				d.off_cnt = q.off_cnt + `BLF_SEC_W'(1);
			end
		end

		// a set beats a clear arriving in the same cycle
		if (reassert) begin
			d.light = BLF_MAX;
			d.dim_cnt = '0;
			d.off_cnt = '0;
		end else if (q.light != BLF_OFF && (sw_off || off_expired)) begin
			d.light = BLF_OFF;
			d.dim_cnt = '0;
			d.off_cnt = '0;
		end else if (q.light != BLF_OFF && (dim_expired || sw_dim_set)) begin
			d.light = BLF_DIM;
			d.dim_cnt = '0;
		end else if (q.light == BLF_DIM && sw_dim_clr) begin
			d.light = BLF_MAX;
			d.dim_cnt = '0;
		end

		// code ramp; the code walks toward whatever the present target is, so a
		// turn-on during a fade-out with ramp_skip_on_reassert clear simply reverses from the code it holds
		if (reassert && ramp_skip_on_reassert && ramping) begin
			d.code = max_code;
			d.step_cnt = '0;
		end else if (!ramping) begin
			d.step_cnt = '0;
		end else if (q.code < target) begin
			if (ramp_up_time == '0) begin
				d.code = target;
				d.step_cnt = '0;
			end else if (step_due_up) begin
				d.code = q.code + `BLF_CODE_W'(1);
				d.step_cnt = '0;
			end else begin
				d.step_cnt = q.step_cnt + `BLF_CNT_W'(1);
			end
		end else begin
			if (ramp_down_time == '0) begin
				d.code = target;
				d.step_cnt = '0;
			end else if (step_due_down) begin
				d.code = q.code - `BLF_CODE_W'(1);
				d.step_cnt = '0;
			end else begin
				d.step_cnt = q.step_cnt + `BLF_CNT_W'(1);
			end
		end

		// current law; codes step in the code domain, so square fades
		// walk the square table rather than the linear one
		d.code_dly = q.code;
		if (current_law_select == `BLF_LAW_LINEAR) begin
			d.current = blf_current_type'(q.code_dly) * blf_current_type'(`BLF_FULL_CODE);
		end else begin
			// cubic encodings reuse the square codes
			d.current = square_current;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// square table
	blf_square_rom u_square_rom (
		.clk(clk),
		.reset(reset),
		.addr(q.code),
		.data(square_current)
	);

	// ==========================================
	// outputs
	assign light_on_request = (q.light != BLF_OFF);
	assign dim_request = (q.light == BLF_DIM);
	assign sink_code = q.code;
	assign sink_current = q.current;
	assign ramp_active = ramping;
endmodule // blf_sequencer

// ==== hdl/blf_square_rom.sv ====
// square-law current table with registered read data
`timescale 1ns/1ns
module blf_square_rom
	import blf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire blf_pkg::blf_code_type addr,
	output blf_pkg::blf_current_type data
);
	typedef struct packed {
		blf_current_type data;
	} blf_rom_state_type;

	blf_rom_state_type rom_q;
	blf_rom_state_type rom_d;

	// ==========================================
	// lookup
	always_comb begin
		rom_d = rom_q;
		rom_d.data = blf_current_type'(addr) * blf_current_type'(addr);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rom_q <= '0;
		end else begin
			rom_q <= rom_d;
		end
	end

	assign data = rom_q.data;
endmodule // blf_square_rom

// ==== verification/blf_sequencer_chk.sv ====
// checker of request, code and current relations at the sequencer ports
`timescale 1ns/1ns
module blf_sequencer_chk
	import blf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic operating_not_standby,
	input wire logic light_on_request_wr,
	input wire logic light_on_request_wdata,
	input wire logic dim_request_wr,
	input wire logic dim_request_wdata,
	input wire logic keypad_matrix_mode,
	input wire logic keypress_wake_light,
	input wire logic key_press,
	input wire blf_pkg::blf_mode_type current_law_select,
	input wire blf_pkg::blf_sel_type ramp_up_time,
	input wire blf_pkg::blf_sel_type ramp_down_time,
	input wire logic ramp_skip_on_reassert,
	input wire logic light_on_request,
	input wire logic dim_request,
	input wire blf_pkg::blf_code_type sink_code,
	input wire blf_pkg::blf_current_type sink_current
);
	// ==========================================
	// helpers
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wake = key_press && keypad_matrix_mode && keypress_wake_light;
	wire run = operating_not_standby;
	sequence lin3;
		(current_law_select == 2'h0) [*3];
	endsequence
	sequence sq3;
		(current_law_select == 2'h1) [*3];
	endsequence
	// ==========================================
	// assertions
	on_write_a: assert property (light_on_request_wr && light_on_request_wdata && run |=> light_on_request)
		else $error("light not on after write");
	off_write_a: assert property (light_on_request_wr && !light_on_request_wdata && !wake && run |=> !light_on_request)
		else $error("light not off after write");
	dim_set_a: assert property (dim_request_wr && dim_request_wdata && light_on_request && !light_on_request_wr
		&& !wake && run |=> dim_request || !light_on_request)
		else $error("dim not entered");
	dim_clear_a: assert property (dim_request_wr && !dim_request_wdata && dim_request && run |=> !dim_request)
		else $error("dim not left");
	key_wake_a: assert property (wake && run |=> light_on_request)
		else $error("key press did not wake");
	dim_on_a: assert property (dim_request |-> light_on_request)
		else $error("dim while off");
	lin_law_a: assert property (lin3 |-> sink_current == blf_current_type'($past(sink_code, 2)) * 14'h7f)
		else $error("linear current wrong");
	sq_law_a: assert property (sq3 |-> sink_current == blf_current_type'($past(sink_code, 2))
		* blf_current_type'($past(sink_code, 2)))
		else $error("square current wrong");
	one_step_a: assert property ($past(ramp_up_time) != 4'h0 && $past(ramp_down_time) != 4'h0
		&& !$past(ramp_skip_on_reassert) |-> sink_code - $past(sink_code) inside {7'h00, 7'h01, 7'h7f})
		else $error("ramp moved more than one code");
endmodule // blf_sequencer_chk

bind blf_sequencer blf_sequencer_chk chk (.clk, .reset, .operating_not_standby, .light_on_request_wr,
	.light_on_request_wdata, .dim_request_wr, .dim_request_wdata, .keypad_matrix_mode, .keypress_wake_light,
	.key_press, .current_law_select, .ramp_up_time, .ramp_down_time, .ramp_skip_on_reassert,
	.light_on_request, .dim_request, .sink_code, .sink_current);

// ==== verification/blf_sequencer_tb_top.sv ====
// self-checking bench for the backlight sequencer
`timescale 1ns/1ns
module blf_sequencer_tb_top;
	import blf_pkg::*;
	logic clk, reset, operating_not_standby, light_on_request_wr, light_on_request_wdata;
	logic dim_request_wr, dim_request_wdata, keypad_matrix_mode, keypress_wake_light, key_press;
	logic ramp_skip_on_reassert, light_on_request, dim_request, ramp_active;
	blf_mode_type current_law_select, ambient_level_select;
	blf_sel_type dim_delay_setting, off_delay_setting, ramp_up_time, ramp_down_time;
	blf_code_type sink_code, c;
	blf_code_type mx[3], dm[3];
	blf_current_type sink_current;
	int fail_count, samples_checked, seed, i;

	// short counts: one second is 20 cycles, one tenth is 127 cycles
	blf_sequencer #(.SEC_CYCLES(20), .TENTH_CYCLES(127)) DUT (
		.clk, .reset, .operating_not_standby, .light_on_request_wr, .light_on_request_wdata,
		.dim_request_wr, .dim_request_wdata, .keypad_matrix_mode, .keypress_wake_light, .key_press,
		.current_law_select, .ambient_level_select, .daylight_max_code(mx[0]), .daylight_dim_code(dm[0]),
		.office_max_code(mx[1]), .office_dim_code(dm[1]), .dark_max_code(mx[2]), .dark_dim_code(dm[2]),
		.dim_delay_setting, .off_delay_setting, .ramp_up_time, .ramp_down_time, .ramp_skip_on_reassert,
		.light_on_request, .dim_request, .sink_code, .sink_current, .ramp_active
	);

	// ==========================================
	// helpers
	function automatic int dly(input int s);
		int t[16] = '{0, 10, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 70, 80, 100, 120};
		return t[s] * 20;
	endfunction
	// any law other than linear reuses the square codes
	function automatic blf_current_type exp_cur(input blf_code_type code, input blf_mode_type law);
		if (law == 2'h0) begin
			return blf_current_type'(code) * 14'h7f;
		end
		return blf_current_type'(code) * blf_current_type'(code);
	endfunction
	task automatic chk_cur(input blf_current_type got, input blf_current_type exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: current %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: flag %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_code(input blf_code_type got, input blf_code_type exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: code %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// callers sit on a falling edge; never call twice back to back
	task automatic wr_on(input logic v);
		light_on_request_wr = 1'b1;
		light_on_request_wdata = v;
		cyc(1);
		light_on_request_wr = 1'b0;
	endtask
	task automatic wr_dim(input logic v);
		dim_request_wr = 1'b1;
		dim_request_wdata = v;
		cyc(1);
		dim_request_wr = 1'b0;
	endtask

	// ==========================================
	// clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		// roughly ten times the length of the sequence
		#1000000;
		fail_count++;
		test_done;
	end
	initial begin
		seed = 64537;
		fail_count = 0;
		samples_checked = 0;
		{reset, operating_not_standby} = 2'h3;
		{light_on_request_wr, light_on_request_wdata, dim_request_wr, dim_request_wdata} = 4'h0;
		{keypad_matrix_mode, keypress_wake_light, key_press, ramp_skip_on_reassert} = 4'h0;
		{current_law_select, ambient_level_select} = 4'h0;
		{dim_delay_setting, off_delay_setting, ramp_up_time, ramp_down_time} = 16'h0000;
		for (i = 0; i < 3; i++) begin
			mx[i] = 7'h40 + 7'($random(seed) & 32'h3f);
			dm[i] = 7'($random(seed) & 32'h3f);
		end
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		wr_dim(1'b1);
		cyc(2);
		chk_bit(dim_request, 1'b0);
		for (i = 0; i < 3; i++) begin
			ambient_level_select = 2'(i);
			current_law_select = 2'(i);
			wr_on(1'b1);
			cyc(3);
			chk_code(sink_code, mx[i]);
			chk_cur(sink_current, exp_cur(mx[i], current_law_select));
			wr_dim(1'b1);
			cyc(3);
			chk_code(sink_code, dm[i]);
			wr_dim(1'b0);
			cyc(3);
			chk_code(sink_code, mx[i]);
			wr_on(1'b0);
			cyc(3);
			chk_code(sink_code, 7'h00);
		end
		{dim_delay_setting, off_delay_setting} = 8'h12;
		wr_on(1'b1);
		cyc(dly(1) - 5);
		chk_bit(dim_request, 1'b0);
		cyc(10);
		chk_code(sink_code, dm[2]);
		cyc(dly(2) - dly(1) - 10);
		chk_bit(light_on_request, 1'b1);
		cyc(10);
		chk_bit(light_on_request, 1'b0);
		for (i = 0; i < 2; i++) begin
			{dim_delay_setting, off_delay_setting} = i ? 8'h01 : 8'h10;
			wr_on(1'b1);
			cyc(150);
			wr_on(1'b1);
			cyc(150);
			chk_bit(i ? light_on_request : !dim_request, 1'b1);
			cyc(60);
			chk_bit(i ? light_on_request : !dim_request, 1'b0);
			wr_on(1'b0);
			cyc(2);
		end
		{dim_delay_setting, off_delay_setting, ramp_up_time, ramp_down_time} = 16'h0011;
		ambient_level_select = 2'h0;
		wr_on(1'b1);
		cyc(mx[0] * 3 - 8);
		chk_bit(ramp_active, 1'b1);
		cyc(14);
		chk_code(sink_code, mx[0]);
		wr_on(1'b0);
		cyc(30);
		c = sink_code;
		wr_on(1'b1);
		cyc(15);
		chk_bit(sink_code > c, 1'b1);
		ramp_skip_on_reassert = 1'b1;
		wr_on(1'b0);
		cyc(20);
		wr_on(1'b1);
		cyc(2);
		chk_code(sink_code, mx[0]);
		{ramp_skip_on_reassert, ramp_down_time} = 5'h00;
		wr_on(1'b0);
		cyc(3);
		chk_code(sink_code, 7'h00);
		keypad_matrix_mode = 1'b1;
		for (i = 0; i < 2; i++) begin
			keypress_wake_light = i[0];
			key_press = 1'b1;
			cyc(1);
			key_press = 1'b0;
			cyc(2);
			chk_bit(light_on_request, i[0]);
		end
		// standby darkens the sink but keeps the request
		operating_not_standby = 1'b0;
		cyc(3);
		chk_code(sink_code, 7'h00);
		chk_bit(light_on_request, 1'b1);
		operating_not_standby = 1'b1;
		cyc(1);
		// random traffic leaves the judging to the checker
		ramp_down_time = 4'h2;
		repeat (400) begin
			{light_on_request_wr, light_on_request_wdata, dim_request_wr, dim_request_wdata, key_press} = 5'($random(seed));
			current_law_select = 2'($random(seed) & 32'h1);
			ramp_skip_on_reassert = 1'($random(seed));
			cyc(1);
		end
		test_done;
	end
endmodule // blf_sequencer_tb_top
